// ---- rtl/dcc_defs.vh ----
// Constants for the DMA channel control block: register byte addresses,
// control word fields, event bits, step and width encodings, reset values.
// Included by every file of the block by its bare name.
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

// Register byte addresses on the Avalon-MM slave
`define DCC_OFS_CTL 24'hFF_E410
`define DCC_OFS_LIST 24'hFF_E414
`define DCC_OFS_LEN 24'hFF_E418
`define DCC_OFS_SRC 24'hFF_E41C
`define DCC_OFS_DST 24'hFF_E420
`define DCC_OFS_IRQ_STATUS 24'hFF_E424
`define DCC_OFS_IRQ_MASK 24'hFF_E428
`define DCC_OFS_STATE 24'hFF_E42C

// Control word field positions
`define DCC_CTL_EN 15
`define DCC_CTL_LOOP 14
`define DCC_CTL_SIZE_HI 13
`define DCC_CTL_SIZE_LO 12
`define DCC_CTL_DST_HI 11
`define DCC_CTL_DST_LO 10
`define DCC_CTL_SRC_HI 9
`define DCC_CTL_SRC_LO 8
`define DCC_CTL_IRQ 7
`define DCC_CTL_JUMP 6
`define DCC_CTL_EOF 5
`define DCC_CTL_HALT 4
`define DCC_CTL_CMD_HI 3
`define DCC_CTL_CMD_LO 0

// Reset values
`define DCC_RST_CTL 16'h0000
`define DCC_RST_ADDR 24'h00_0000
`define DCC_RST_LEN 16'h0000
`define DCC_RST_EVT 2'h0

// Event bits of the interrupt status and mask registers
`define DCC_EVT_BUF_DONE 0
`define DCC_EVT_CFG_ERR 1
`define DCC_EVT_W 2

// Address step encodings
`define DCC_STEP_FIXED 2'h0
`define DCC_STEP_INC 2'h1
`define DCC_STEP_DEC 2'h2
`define DCC_STEP_RSVD 2'h3

// Transfer width encodings and their byte counts
`define DCC_SIZE_BYTE 2'h0
`define DCC_SIZE_WORD 2'h1
`define DCC_SIZE_QUAD 2'h2
`define DCC_SIZE_RSVD 2'h3
`define DCC_BYTES_BYTE 24'h00_0001
`define DCC_BYTES_WORD 24'h00_0002
`define DCC_BYTES_QUAD 24'h00_0004

// Descriptor stride for the sequential list advance
`define DCC_LIST_STRIDE 24'h00_0010

`endif

// ---- rtl/dcc_addr_step.v ----
// Address stepper: next source or destination address after one transfer.
// Assumes the step and width codes are already checked for reserved values.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defs.vh"

module dcc_addr_step (
  input wire [23:0] addr,
  input wire [1:0] step,
  input wire [1:0] width,
  output reg [23:0] next_addr
);

  reg [23:0] amount;

  // Byte count of one transfer, then fixed, up or down
  always @* begin
    case (width)
      `DCC_SIZE_WORD: amount = `DCC_BYTES_WORD;
      `DCC_SIZE_QUAD: amount = `DCC_BYTES_QUAD;
      default: amount = `DCC_BYTES_BYTE;
    endcase
    case (step)
      `DCC_STEP_INC: next_addr = addr + amount;
      `DCC_STEP_DEC: next_addr = addr - amount;
      default: next_addr = addr; // Fixed address, reserved never reaches here
    endcase
  end

endmodule
`default_nettype wire

// ---- rtl/dcc_irq.v ----
// Interrupt status and mask: sticky event bits, write one to clear,
// mask gates them onto one level output. Assumes a synchronous reset copy.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defs.vh"

module dcc_irq (
  input wire clk,
  input wire rst_n,
  input wire [`DCC_EVT_W-1:0] event_set,
  input wire clear_wr,
  input wire [`DCC_EVT_W-1:0] clear_data,
  input wire mask_wr,
  input wire [`DCC_EVT_W-1:0] mask_data,
  output reg [`DCC_EVT_W-1:0] status,
  output reg [`DCC_EVT_W-1:0] mask,
  output wire irq
);

  wire [`DCC_EVT_W-1:0] clear_bits;

  assign clear_bits = clear_wr ? clear_data : `DCC_RST_EVT;

  // Sticky bits: a new event wins over a clear in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= `DCC_RST_EVT;
      mask <= `DCC_RST_EVT;
    end else begin
      status <= (status & ~clear_bits) | event_set;
      if (mask_wr) begin
        mask <= mask_data;
      end
    end
  end

  // Level output while any unmasked bit stands
  assign irq = |(status & mask);

endmodule
`default_nettype wire

// ---- rtl/dcc_channel_top.v ----
// DMA channel control: control word, buffer sequencing in direct and
// linked-list operation, command bus and frame-end status capture.
// Assumes an Avalon-MM master on the register side, a memory mover on the
// transfer port, a descriptor port, and peripherals on the command port.
//
// How it works
// - Direct enable write or descriptor enable starts channel
// - Loop bit set leaves descriptor unwritten at close
// - Width field picks byte, word or quad
// - Destination step: fixed, increment or decrement
// - Source step: fixed, increment or decrement
// - Buffer done raises interrupt only if enabled
// - List pointer adds sixteen or loads next
// - Frame-end bit marks last buffer of frame
// - Halt bit stops list after current buffer
// - First transfer drives nibble with command strobe
// - Frame end fetches peripheral status into nibble
// - List mode writes nibble back to descriptor
// - Nibble is forwarded, never interpreted
// - List pointer low byte write starts list
// - Length drops by one per transfer
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defs.vh"

module dcc_channel_top (
  input wire CORE_CLK,
  input wire RST_B,
  input wire [23:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  output wire IRQ,
  output wire XFER_REQ,
  output wire [23:0] XFER_SRC_ADDR,
  output wire [23:0] XFER_DST_ADDR,
  output wire [1:0] XFER_WIDTH,
  input wire XFER_DONE,
  output wire DESC_RD_REQ,
  output wire DESC_WR_REQ,
  output wire [23:0] DESC_ADDR,
  output wire [15:0] DESC_WR_CTL,
  input wire DESC_RD_ACK,
  input wire DESC_WR_ACK,
  input wire [15:0] DESC_CTL,
  input wire [15:0] DESC_LEN,
  input wire [23:0] DESC_SRC,
  input wire [23:0] DESC_DST,
  input wire [23:0] DESC_NEXT,
  output reg [3:0] PERIPH_CMD_BUS,
  output reg PERIPH_CMD_STROBE,
  output wire STATUS_REQ,
  input wire STATUS_ACK,
  input wire [3:0] STATUS_DATA
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_FETCH = 4'h1;
  localparam [3:0] ST_FIRST = 4'h2;
  localparam [3:0] ST_XFER = 4'h3;
  localparam [3:0] ST_END = 4'h4;
  localparam [3:0] ST_STATUS = 4'h5;
  localparam [3:0] ST_CLOSE = 4'h6;
  localparam [3:0] ST_WB = 4'h7;
  localparam [3:0] ST_NEXT = 4'h8;

  reg rst_meta;
  reg rst_sync;
  wire rst_n;
  reg [3:0] state;
  reg list_mode;
  reg [15:0] ctl;
  reg [23:0] list_pointer;
  reg [23:0] next_pointer;
  reg [15:0] length;
  reg [23:0] src_addr;
  reg [23:0] dst_addr;
  reg rd_valid;
  reg [`DCC_EVT_W-1:0] events;
  wire [23:0] next_src;
  wire [23:0] next_dst;
  wire [`DCC_EVT_W-1:0] irq_status;
  wire [`DCC_EVT_W-1:0] irq_mask;
  wire [1:0] transfer_width;
  wire [1:0] dest_step;
  wire [1:0] source_step;
  wire cfg_error;
  wire wr_ctl;
  wire wr_list;
  wire wr_len;
  wire wr_src;
  wire wr_dst;
  wire idle;

  // Reset: asynchronous assert, release through two flip-flops
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign rst_n = rst_sync;

  // Control word fields
  assign transfer_width = ctl[`DCC_CTL_SIZE_HI:`DCC_CTL_SIZE_LO];
  assign dest_step = ctl[`DCC_CTL_DST_HI:`DCC_CTL_DST_LO];
  assign source_step = ctl[`DCC_CTL_SRC_HI:`DCC_CTL_SRC_LO];
  assign cfg_error = (transfer_width == `DCC_SIZE_RSVD) ||
                     (dest_step == `DCC_STEP_RSVD) ||
                     (source_step == `DCC_STEP_RSVD);
  assign idle = (state == ST_IDLE);

  // Register write decode
  assign wr_ctl = AVS_WRITE && (AVS_ADDRESS == `DCC_OFS_CTL);
  assign wr_list = AVS_WRITE && (AVS_ADDRESS == `DCC_OFS_LIST);
  assign wr_len = AVS_WRITE && (AVS_ADDRESS == `DCC_OFS_LEN) && idle;
  assign wr_src = AVS_WRITE && (AVS_ADDRESS == `DCC_OFS_SRC) && idle;
  assign wr_dst = AVS_WRITE && (AVS_ADDRESS == `DCC_OFS_DST) && idle;

  // Writes finish at once; reads wait one cycle for registered data
  assign AVS_WAITREQUEST = AVS_READ && !rd_valid;

  // Read data register and its valid flag
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      AVS_READDATA <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= AVS_READ && !rd_valid;
      if (AVS_READ && !rd_valid) begin
        case (AVS_ADDRESS)
          `DCC_OFS_CTL: AVS_READDATA <= {16'h0000, ctl};
          `DCC_OFS_LIST: AVS_READDATA <= {8'h00, list_pointer};
          `DCC_OFS_LEN: AVS_READDATA <= {16'h0000, length};
          `DCC_OFS_SRC: AVS_READDATA <= {8'h00, src_addr};
          `DCC_OFS_DST: AVS_READDATA <= {8'h00, dst_addr};
          `DCC_OFS_IRQ_STATUS: AVS_READDATA <= {30'h0000_0000, irq_status};
          `DCC_OFS_IRQ_MASK: AVS_READDATA <= {30'h0000_0000, irq_mask};
          `DCC_OFS_STATE: AVS_READDATA <= {27'h000_0000, list_mode, state};
          default: AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Address steppers for source and destination
  dcc_addr_step u_src_step (
    .addr(src_addr),
    .step(source_step),
    .width(transfer_width),
    .next_addr(next_src)
  );

  dcc_addr_step u_dst_step (
    .addr(dst_addr),
    .step(dest_step),
    .width(transfer_width),
    .next_addr(next_dst)
  );

  // Interrupt status and mask
  dcc_irq u_irq (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .event_set(events),
    .clear_wr(AVS_WRITE && (AVS_ADDRESS == `DCC_OFS_IRQ_STATUS) && AVS_BYTEENABLE[0]),
    .clear_data(AVS_WRITEDATA[`DCC_EVT_W-1:0]),
    .mask_wr(AVS_WRITE && (AVS_ADDRESS == `DCC_OFS_IRQ_MASK) && AVS_BYTEENABLE[0]),
    .mask_data(AVS_WRITEDATA[`DCC_EVT_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(IRQ)
  );

  // Handshake requests follow the state
  assign XFER_REQ = (state == ST_XFER);
  assign DESC_RD_REQ = (state == ST_FETCH);
  assign DESC_WR_REQ = (state == ST_WB);
  assign STATUS_REQ = (state == ST_STATUS);
  assign XFER_SRC_ADDR = src_addr;
  assign XFER_DST_ADDR = dst_addr;
  assign XFER_WIDTH = transfer_width;
  assign DESC_ADDR = list_pointer;
  assign DESC_WR_CTL = ctl;

  // Sequencer, control word and channel registers
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      list_mode <= 1'b0;
      ctl <= `DCC_RST_CTL;
      list_pointer <= `DCC_RST_ADDR;
      next_pointer <= `DCC_RST_ADDR;
      length <= `DCC_RST_LEN;
      src_addr <= `DCC_RST_ADDR;
      dst_addr <= `DCC_RST_ADDR;
      PERIPH_CMD_BUS <= 4'h0;
      PERIPH_CMD_STROBE <= 1'b0;
      events <= `DCC_RST_EVT;
    end else begin
      PERIPH_CMD_STROBE <= 1'b0;
      events <= `DCC_RST_EVT;
      // Software side of the register file
      if (wr_ctl && AVS_BYTEENABLE[0]) begin
        ctl[7:0] <= AVS_WRITEDATA[7:0];
      end
      if (wr_ctl && AVS_BYTEENABLE[1]) begin
        ctl[15:8] <= AVS_WRITEDATA[15:8];
      end
      if (wr_list && AVS_BYTEENABLE[0]) begin
        list_pointer[7:0] <= AVS_WRITEDATA[7:0];
      end
      if (wr_list && AVS_BYTEENABLE[1]) begin
        list_pointer[15:8] <= AVS_WRITEDATA[15:8];
      end
      if (wr_list && AVS_BYTEENABLE[2]) begin
        list_pointer[23:16] <= AVS_WRITEDATA[23:16];
      end
      if (wr_len) begin
        length <= AVS_WRITEDATA[15:0];
      end
      if (wr_src) begin
        src_addr <= AVS_WRITEDATA[23:0];
      end
      if (wr_dst) begin
        dst_addr <= AVS_WRITEDATA[23:0];
      end
      // Sequencer; hardware updates below take priority over software
      case (state)
        ST_IDLE: begin
          if (wr_list && AVS_BYTEENABLE[0]) begin
            list_mode <= 1'b1;
            state <= ST_FETCH;
          end else if (wr_ctl && AVS_BYTEENABLE[1] && AVS_WRITEDATA[`DCC_CTL_EN]) begin
            list_mode <= 1'b0;
            state <= ST_FIRST;
          end
        end
        ST_FETCH: begin
          if (DESC_RD_ACK) begin
            ctl <= DESC_CTL;
            length <= DESC_LEN;
            src_addr <= DESC_SRC;
            dst_addr <= DESC_DST;
            next_pointer <= DESC_NEXT;
            if (DESC_CTL[`DCC_CTL_EN]) begin
              state <= ST_FIRST;
            end else begin
              list_mode <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        ST_FIRST: begin
          if (cfg_error) begin
            events[`DCC_EVT_CFG_ERR] <= 1'b1;
            ctl[`DCC_CTL_EN] <= 1'b0;
            list_mode <= 1'b0;
            state <= ST_IDLE;
          end else if (length == 16'h0000) begin
            state <= ST_END;
          end else begin
            // Nibble goes out untouched with a one-cycle strobe
            PERIPH_CMD_BUS <= ctl[`DCC_CTL_CMD_HI:`DCC_CTL_CMD_LO];
            PERIPH_CMD_STROBE <= 1'b1;
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (XFER_DONE) begin
            length <= length - 16'h0001;
            src_addr <= next_src;
            dst_addr <= next_dst;
            if (length == 16'h0001) begin
              state <= ST_END;
            end
          end
        end
        ST_END: begin
          if (ctl[`DCC_CTL_EOF]) begin
            state <= ST_STATUS;
          end else begin
            state <= ST_CLOSE;
          end
        end
        ST_STATUS: begin
          if (STATUS_ACK) begin
            ctl[`DCC_CTL_CMD_HI:`DCC_CTL_CMD_LO] <= STATUS_DATA;
            state <= ST_CLOSE;
          end
        end
        ST_CLOSE: begin
          if (list_mode && !ctl[`DCC_CTL_LOOP]) begin
            state <= ST_WB;
          end else begin
            state <= ST_NEXT;
          end
        end
        ST_WB: begin
          if (DESC_WR_ACK) begin
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          events[`DCC_EVT_BUF_DONE] <= ctl[`DCC_CTL_IRQ];
          if (list_mode) begin
            if (ctl[`DCC_CTL_JUMP]) begin
              list_pointer <= next_pointer;
            end else begin
              list_pointer <= list_pointer + `DCC_LIST_STRIDE;
            end
            if (ctl[`DCC_CTL_HALT]) begin
              ctl[`DCC_CTL_EN] <= 1'b0;
              list_mode <= 1'b0;
              state <= ST_IDLE;
            end else begin
              state <= ST_FETCH;
            end
          end else begin
            ctl[`DCC_CTL_EN] <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // Software clearing the enable aborts an active channel
      if (!idle && wr_ctl && AVS_BYTEENABLE[1] && !AVS_WRITEDATA[`DCC_CTL_EN]) begin
        ctl[`DCC_CTL_EN] <= 1'b0;
        list_mode <= 1'b0;
        state <= ST_IDLE;
      end
    end
  end

endmodule
`default_nettype wire

// ---- verif/dcc_far_model.sv ----
// Far-side model: memory mover, descriptor memory and peripheral status.
// Assumes one clock; slow sets the wait cycles before each answer.
`timescale 1ns/1ps
`default_nettype none
module dcc_far_model (
  input wire clk,
  input wire xfer_req,
  output wire xfer_done,
  input wire desc_rd_req,
  input wire desc_wr_req,
  input wire [23:0] desc_addr,
  input wire [15:0] desc_wr_ctl,
  output wire desc_rd_ack,
  output wire desc_wr_ack,
  output wire [15:0] desc_ctl,
  output wire [15:0] desc_len,
  output wire [23:0] desc_src,
  output wire [23:0] desc_dst,
  output wire [23:0] desc_next,
  input wire status_req,
  output wire status_ack,
  output wire [3:0] status_data
);
  logic [15:0] mctl [8];
  logic [15:0] mlen [8];
  logic [23:0] msrc [8];
  logic [23:0] mdst [8];
  logic [23:0] mnext [8];
  logic [3:0] stat = 4'h0;
  logic [15:0] wr_ctl = 16'h0000;
  logic [23:0] rd_adr [$];
  int slow = 0;
  int cnt = 0;
  int rd_cnt = 0;
  int wr_cnt = 0;
  wire busy = xfer_req | desc_rd_req | desc_wr_req | status_req;
  wire go = busy && cnt == 0;
  wire [2:0] ix = desc_addr[6:4];
  // Answers come once the wait count has run out
  assign xfer_done = xfer_req && go;
  assign desc_rd_ack = desc_rd_req && go;
  assign desc_wr_ack = desc_wr_req && go;
  assign status_ack = status_req && go;
  // Data lines carry the inverse outside an acknowledge
  assign desc_ctl = desc_rd_ack ? mctl[ix] : ~mctl[ix];
  assign desc_len = desc_rd_ack ? mlen[ix] : ~mlen[ix];
  assign desc_src = desc_rd_ack ? msrc[ix] : ~msrc[ix];
  assign desc_dst = desc_rd_ack ? mdst[ix] : ~mdst[ix];
  assign desc_next = desc_rd_ack ? mnext[ix] : ~mnext[ix];
  assign status_data = status_ack ? stat : ~stat;
  // Wait counter and a record of descriptor traffic
  always @(posedge clk) begin
    if (go) cnt <= slow;
    else if (busy) cnt <= cnt - 1;
    if (desc_rd_ack) begin
      rd_cnt <= rd_cnt + 1;
      rd_adr.push_back(desc_addr);
    end
    if (desc_wr_ack) begin
      wr_cnt <= wr_cnt + 1;
      wr_ctl <= desc_wr_ctl;
    end
  end
endmodule
`default_nettype wire

// ---- verif/dcc_channel_top_assertions.sv ----
// Checker for the channel top: bus wait, command strobe, request holds, steps.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module dcc_top_checker (
  input wire CORE_CLK,
  input wire RST_B,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire AVS_WAITREQUEST,
  input wire XFER_REQ,
  input wire XFER_DONE,
  input wire [23:0] XFER_SRC_ADDR,
  input wire [23:0] XFER_DST_ADDR,
  input wire [1:0] XFER_WIDTH,
  input wire DESC_WR_REQ,
  input wire DESC_WR_ACK,
  input wire [3:0] PERIPH_CMD_BUS,
  input wire PERIPH_CMD_STROBE,
  input wire STATUS_REQ,
  input wire STATUS_ACK,
  input wire DESC_RD_REQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Address kept, or moved by one unit of the width either way
  function automatic bit step_ok(input logic [23:0] a, input logic [23:0] b, input logic [1:0] w);
    logic [23:0] n;
    n = 24'h00_0001 << w;
    return b == a || b == a + n || b == a - n;
  endfunction
  sequence s_rd_wait; AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endsequence
  sequence s_cmd_pulse; PERIPH_CMD_STROBE ##1 !PERIPH_CMD_STROBE; endsequence
  property p_rd_wait; $rose(AVS_READ) |-> s_rd_wait; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
  property p_cmd_first; $rose(XFER_REQ) |-> s_cmd_pulse; endproperty
  a_cmd_first: assert property (p_cmd_first) else $error("no strobe at first transfer");
  property p_cmd_only; PERIPH_CMD_STROBE |-> XFER_REQ && !$past(XFER_REQ); endproperty
  a_cmd_only: assert property (p_cmd_only) else $error("strobe outside first transfer");
  property p_nib_hold; $changed(PERIPH_CMD_BUS) |-> PERIPH_CMD_STROBE; endproperty
  a_nib_hold: assert property (p_nib_hold) else $error("command bus moved alone");
  property p_xfer_hold; XFER_REQ && !XFER_DONE && !AVS_WRITE |=> XFER_REQ; endproperty
  a_xfer_hold: assert property (p_xfer_hold) else $error("transfer request dropped");
  property p_step;
    XFER_REQ && XFER_DONE |=> step_ok($past(XFER_SRC_ADDR), XFER_SRC_ADDR, $past(XFER_WIDTH))
      && step_ok($past(XFER_DST_ADDR), XFER_DST_ADDR, $past(XFER_WIDTH));
  endproperty
  a_step: assert property (p_step) else $error("address step wrong");
  property p_width_ok; XFER_REQ |-> XFER_WIDTH != 2'h3; endproperty
  a_width_ok: assert property (p_width_ok) else $error("reserved width in use");
  property p_one_req; $onehot0({XFER_REQ, DESC_RD_REQ, DESC_WR_REQ, STATUS_REQ}); endproperty
  a_one_req: assert property (p_one_req) else $error("two requests at once");
  property p_stat_hold; STATUS_REQ && !STATUS_ACK && !AVS_WRITE |=> STATUS_REQ; endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("status request dropped");
  property p_wb_hold; DESC_WR_REQ && !DESC_WR_ACK && !AVS_WRITE |=> DESC_WR_REQ; endproperty
  a_wb_hold: assert property (p_wb_hold) else $error("write-back dropped");
endmodule
bind dcc_channel_top dcc_top_checker u_chk (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .XFER_REQ(XFER_REQ), .XFER_DONE(XFER_DONE),
  .XFER_SRC_ADDR(XFER_SRC_ADDR), .XFER_DST_ADDR(XFER_DST_ADDR), .XFER_WIDTH(XFER_WIDTH),
  .DESC_WR_REQ(DESC_WR_REQ), .DESC_WR_ACK(DESC_WR_ACK), .PERIPH_CMD_BUS(PERIPH_CMD_BUS),
  .PERIPH_CMD_STROBE(PERIPH_CMD_STROBE), .STATUS_REQ(STATUS_REQ), .STATUS_ACK(STATUS_ACK),
  .DESC_RD_REQ(DESC_RD_REQ)
);
`default_nettype wire

// ---- verif/dcc_channel_top_tb.sv ----
// Bench: direct buffers over all widths and steps, reserved codes, frame-end
// status and a two-entry list. Assumes the far-side model answers requests.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defs.vh"
module dcc_channel_top_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [23:0] adr = 24'h00_0000;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] be = 4'h0;
  wire [31:0] rdata;
  wire wq, irq, xreq, xdone, drq, dwq, dra, dwa, cstb, sreq, sack;
  wire [23:0] xsrc, xdst, dadr, dsrc, ddst, dnext;
  wire [1:0] xw;
  wire [15:0] dwc, dctl, dlen;
  wire [3:0] cbus, sdat;
  int err_count = 0;
  int checks_done = 0;
  int ndone = 0;
  logic [3:0] nq [$];
  dcc_channel_top DUT (
    .CORE_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
    .IRQ(irq), .XFER_REQ(xreq), .XFER_SRC_ADDR(xsrc), .XFER_DST_ADDR(xdst), .XFER_WIDTH(xw),
    .XFER_DONE(xdone), .DESC_RD_REQ(drq), .DESC_WR_REQ(dwq), .DESC_ADDR(dadr),
    .DESC_WR_CTL(dwc), .DESC_RD_ACK(dra), .DESC_WR_ACK(dwa), .DESC_CTL(dctl), .DESC_LEN(dlen),
    .DESC_SRC(dsrc), .DESC_DST(ddst), .DESC_NEXT(dnext), .PERIPH_CMD_BUS(cbus),
    .PERIPH_CMD_STROBE(cstb), .STATUS_REQ(sreq), .STATUS_ACK(sack), .STATUS_DATA(sdat)
  );
  dcc_far_model pm (
    .clk(clk), .xfer_req(xreq), .xfer_done(xdone), .desc_rd_req(drq), .desc_wr_req(dwq),
    .desc_addr(dadr), .desc_wr_ctl(dwc), .desc_rd_ack(dra), .desc_wr_ack(dwa),
    .desc_ctl(dctl), .desc_len(dlen), .desc_src(dsrc), .desc_dst(ddst), .desc_next(dnext),
    .status_req(sreq), .status_ack(sack), .status_data(sdat)
  );
  // Clock of 4 ns
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobed nibbles against the expected queue, and a count of transfers
  always @(posedge clk) begin
    if (cstb === 1'b1) chk({28'h0, cbus}, nq.size() > 0 ? {28'h0, nq.pop_front()} : 32'h10);
    if (xreq === 1'b1 && xdone === 1'b1) ndone++;
  end
  // One Avalon-MM cycle, entered and left just after a rising edge
  task automatic bus(input logic w, input logic [23:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    adr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_idle;
    logic [31:0] q;
    do bus(1'b0, `DCC_OFS_STATE, 32'h0, 4'hf, q); while (q[3:0] !== 4'h0);
  endtask
  function automatic logic [23:0] adv(input logic [23:0] a, input int s, input int w, input int n);
    adv = s == 1 ? a + n * (1 << w) : s == 2 ? a - n * (1 << w) : a;
  endfunction
  task results;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    results();
  end
  initial begin
    logic [1:0] w, ds, ss;
    logic [3:0] nib;
    logic [23:0] src, dst;
    logic [31:0] q;
    logic [15:0] c;
    int len, n0, m;
    void'($urandom(32'h30ae));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values, with an ignored write to an unmapped place
    bus(1'b1, 24'hFF_E430, 32'hFFFF_FFFF, 4'hf, q);
    for (int a = 0; a < 9; a++) begin
      bus(1'b0, 24'hFF_E410 + 4 * a, 32'h0, 4'hf, q);
      chk(q, 32'h0);
    end
    $display("test reset done");
    // Direct buffers over every non-reserved width and step code
    for (int i = 0; i < 9; i++) begin
      w = i % 3;
      ds = i % 3;
      ss = (i / 3) % 3;
      len = $urandom_range(4, 1);
      src = $urandom;
      dst = $urandom;
      nib = $urandom;
      m = (i % 2 == 0);
      pm.slow = i % 3;
      bus(1'b1, `DCC_OFS_SRC, {8'h0, src}, 4'hf, q);
      bus(1'b1, `DCC_OFS_DST, {8'h0, dst}, 4'hf, q);
      bus(1'b1, `DCC_OFS_LEN, len, 4'hf, q);
      bus(1'b1, `DCC_OFS_IRQ_MASK, m, 4'h1, q);
      c = {2'b10, w, ds, ss, 4'h8, nib};
      nq.push_back(nib);
      n0 = ndone;
      bus(1'b1, `DCC_OFS_CTL, {16'h0, c}, 4'h3, q);
      wait_idle();
      chk(ndone - n0, len);
      bus(1'b0, `DCC_OFS_LEN, 32'h0, 4'hf, q);
      chk(q, 32'h0);
      bus(1'b0, `DCC_OFS_SRC, 32'h0, 4'hf, q);
      chk(q, {8'h0, adv(src, ss, w, len)});
      bus(1'b0, `DCC_OFS_DST, 32'h0, 4'hf, q);
      chk(q, {8'h0, adv(dst, ds, w, len)});
      bus(1'b0, `DCC_OFS_CTL, 32'h0, 4'hf, q);
      chk(q, {17'h0, c[14:0]});
      bus(1'b0, `DCC_OFS_IRQ_STATUS, 32'h0, 4'hf, q);
      chk(q, 32'h1);
      chk({31'h0, irq}, m);
      bus(1'b1, `DCC_OFS_IRQ_STATUS, 32'h1, 4'h1, q);
      bus(1'b0, `DCC_OFS_IRQ_STATUS, 32'h0, 4'hf, q);
      chk(q, 32'h0);
    end
    $display("test direct done");
    // Frame end without buffer interrupt: status replaces the nibble
    pm.stat = $urandom;
    bus(1'b1, `DCC_OFS_LEN, 32'h1, 4'hf, q);
    c = {8'h91, 4'h2, 4'h6};
    nq.push_back(4'h6);
    bus(1'b1, `DCC_OFS_CTL, {16'h0, c}, 4'h3, q);
    wait_idle();
    bus(1'b0, `DCC_OFS_CTL, 32'h0, 4'hf, q);
    chk(q, {17'h0, c[14:4], pm.stat});
    bus(1'b0, `DCC_OFS_IRQ_STATUS, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    $display("test frame end done");
    // Reserved width and step codes move nothing
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `DCC_OFS_LEN, 32'h3, 4'hf, q);
      c = {2'b10, k == 0 ? 2'h3 : 2'h0, k == 1 ? 2'h3 : 2'h1, k == 2 ? 2'h3 : 2'h1, 8'h80};
      n0 = ndone;
      bus(1'b1, `DCC_OFS_CTL, {16'h0, c}, 4'h3, q);
      wait_idle();
      chk(ndone - n0, 0);
      bus(1'b0, `DCC_OFS_IRQ_STATUS, 32'h0, 4'hf, q);
      chk(q, 32'h2);
      bus(1'b1, `DCC_OFS_IRQ_STATUS, 32'h3, 4'h1, q);
    end
    $display("test reserved done");
    // Empty buffer closes at once; clearing the enable aborts a busy one
    pm.slow = 4;
    bus(1'b1, `DCC_OFS_LEN, 32'h0000_0000, 4'hf, q);
    n0 = ndone;
    bus(1'b1, `DCC_OFS_CTL, 32'h0000_8080, 4'h3, q);
    wait_idle();
    chk(ndone - n0, 0);
    bus(1'b0, `DCC_OFS_IRQ_STATUS, 32'h0, 4'hf, q);
    chk(q, 32'h1);
    bus(1'b1, `DCC_OFS_IRQ_STATUS, 32'h1, 4'h1, q);
    bus(1'b1, `DCC_OFS_LEN, 32'h0000_00C8, 4'hf, q);
    nq.push_back(4'h0);
    n0 = ndone;
    bus(1'b1, `DCC_OFS_CTL, 32'h0000_8080, 4'h3, q);
    bus(1'b1, `DCC_OFS_LEN, 32'h0000_0005, 4'hf, q);
    bus(1'b1, `DCC_OFS_CTL, 32'h0000_0080, 4'h3, q);
    wait_idle();
    chk(ndone - n0 < 10, 1);
    bus(1'b0, `DCC_OFS_LEN, 32'h0, 4'hf, q);
    chk(q, 32'h0000_00C8 - (ndone - n0));
    $display("test abort done");
    // Two descriptors: advance by 16 with write-back, then jump and halt
    pm.mctl[0] = 16'h95A5;
    pm.mlen[0] = 16'h0002;
    pm.msrc[0] = 24'h00_2000;
    pm.mdst[0] = 24'h00_3000;
    pm.mnext[0] = 24'h00_0770;
    pm.mctl[1] = 16'hC05A;
    pm.mlen[1] = 16'h0001;
    pm.msrc[1] = 24'h00_4000;
    pm.mdst[1] = 24'h00_5000;
    pm.mnext[1] = 24'h00_0170;
    pm.stat = 4'h9;
    pm.slow = 1;
    nq.push_back(4'h5);
    nq.push_back(4'hA);
    bus(1'b1, `DCC_OFS_LIST, 32'h0000_0100, 4'h7, q);
    wait_idle();
    chk(pm.rd_cnt, 2);
    chk({8'h0, pm.rd_adr[0]}, 32'h100);
    chk({8'h0, pm.rd_adr[1]}, 32'h110);
    chk(pm.wr_cnt, 1);
    chk({16'h0, pm.wr_ctl}, 32'h95A9);
    bus(1'b0, `DCC_OFS_LIST, 32'h0, 4'hf, q);
    chk(q, 32'h0000_0170);
    bus(1'b0, `DCC_OFS_IRQ_STATUS, 32'h0, 4'hf, q);
    chk(q, 32'h1);
    $display("test list done");
    chk(nq.size(), 0);
    results();
  end
endmodule
`default_nettype wire
